// file: src/ahbw_dev_end.sv
// device end of the asynchronous host port with ready-driven wait states
// Functional notes
// [RULE_01] host holds strobe until ready returns high
// [RULE_02] new access accepted while ready still low
// [RULE_03] bank-select access has no wait
// [RULE_04] normal mode queue-data read waits 80 ns
// [RULE_05] turbo mode queue-data read waits 40 ns
// [RULE_06] turbo wait only with turbo driver, revision
// [RULE_07] queue-data write waits 36 ns, up to 50
// [RULE_08] ready drops soon after read strobe asserts
// [RULE_09] ready drops soon after write strobe releases
// [RULE_10] read data valid before ready rises
// [RULE_11] write data captured at write strobe release
// [RULE_12] strobe mode latches address on strobe rise
// [RULE_13] tied mode host holds address past strobe
`timescale 1ns/100ps
module ahbw_dev_end (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// host pins
	ahbw_if.dev                              bus,
	// mode selects
	input  wire logic                        turbo_mode,
	input  wire logic                        addr_strobe_mode,
	// register side
	output logic                             reg_rd,
	output logic                             reg_wr,
	output logic [ahbw_pkg::ADDR_W-1:0]      reg_addr,
	output logic                             reg_qual,
	output logic [ahbw_pkg::BE_W-1:0]        reg_be_n,
	output logic [ahbw_pkg::DATA_W-1:0]      reg_wdata,
	input  wire logic [ahbw_pkg::DATA_W-1:0] reg_rdata
);

	// ------------------------------------------------------------
	// strobe edge detection
	// ------------------------------------------------------------
	logic                        rd_q;
	logic                        wr_q;
	logic                        as_q;
	logic                        rd_start;
	logic                        wr_end;
	logic                        as_rise;

	// previous strobe levels; reset as idle so no false edge
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_q <= 1'b1;
			wr_q <= 1'b1;
			as_q <= 1'b1;
		end
		else
		begin
			rd_q <= bus.read_strobe_n;
			wr_q <= bus.write_strobe_n;
			as_q <= bus.addr_latch_strobe_n;
		end
	end

	// host logic shares our clock, so strobes are used unsynchronised
	assign rd_start = rd_q & ~bus.read_strobe_n;
	assign wr_end   = ~wr_q & bus.write_strobe_n;
	assign as_rise  = ~as_q & bus.addr_latch_strobe_n;

	// ------------------------------------------------------------
	// address capture
	// ------------------------------------------------------------
	logic [ahbw_pkg::ADDR_W-1:0] lat_addr;
	logic                        lat_qual;
	logic [ahbw_pkg::BE_W-1:0]   lat_be_n;
	logic [ahbw_pkg::ADDR_W-1:0] held_addr;
	logic                        held_qual;
	logic [ahbw_pkg::BE_W-1:0]   held_be_n;

	// strobe mode: address, qualifier and lanes taken on strobe rise
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lat_addr <= ahbw_pkg::ADDR_RST;
			lat_qual <= 1'b0;
			lat_be_n <= ahbw_pkg::BE_N_RST;
		end
		else if (as_rise)
		begin
			lat_addr <= bus.host_addr_lines; // RULE_12
			lat_qual <= bus.addr_qualifier; // RULE_12
			lat_be_n <= bus.byte_lane_enable_n; // RULE_12
		end
	end

	// tied mode: keep the last address seen under the write strobe,
	// so the write decode does not depend on the host's short hold
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			held_addr <= ahbw_pkg::ADDR_RST;
			held_qual <= 1'b0;
			held_be_n <= ahbw_pkg::BE_N_RST;
		end
		else if (!bus.write_strobe_n)
		begin
			held_addr <= bus.host_addr_lines; // RULE_13
			held_qual <= bus.addr_qualifier;
			held_be_n <= bus.byte_lane_enable_n;
		end
	end

	// ------------------------------------------------------------
	// address of the access being started
	// ------------------------------------------------------------
	logic [ahbw_pkg::ADDR_W-1:0] rd_addr;
	logic                        rd_qual;
	logic [ahbw_pkg::BE_W-1:0]   rd_be_n;
	logic [ahbw_pkg::ADDR_W-1:0] wr_addr;
	logic                        wr_qual;
	logic [ahbw_pkg::BE_W-1:0]   wr_be_n;

	// reads use the live lines in tied mode, the latch otherwise;
	// the latch loads at the same edge as a strobe rise, so in that cycle
	// the live lines pass straight through instead of the stale latch
	always_comb
	begin
		rd_addr = (addr_strobe_mode && !as_rise) ? lat_addr : bus.host_addr_lines; // RULE_12
		rd_qual = (addr_strobe_mode && !as_rise) ? lat_qual : bus.addr_qualifier;
		rd_be_n = (addr_strobe_mode && !as_rise) ? lat_be_n : bus.byte_lane_enable_n;
		wr_addr = addr_strobe_mode ? (as_rise ? bus.host_addr_lines : lat_addr) : held_addr;
		wr_qual = addr_strobe_mode ? (as_rise ? bus.addr_qualifier : lat_qual) : held_qual;
		wr_be_n = addr_strobe_mode ? (as_rise ? bus.byte_lane_enable_n : lat_be_n) : held_be_n;
	end

	// ------------------------------------------------------------
	// wait length selection
	// ------------------------------------------------------------
	function automatic logic [ahbw_pkg::CNT_W-1:0] wait_cycles(
		input logic                        is_write,
		input logic [ahbw_pkg::ADDR_W-1:0] a,
		input logic                        turbo
	);
		logic [ahbw_pkg::CNT_W-1:0] w;
		w = ahbw_pkg::CNT_RST;
		if (a == ahbw_pkg::BANK_SEL_ADDR)
			w = ahbw_pkg::BANK_SEL_WAIT_CYC; // RULE_03
		else if (is_write && a == ahbw_pkg::QUEUE_DATA_ADDR)
			w = ahbw_pkg::WR_WAIT_QUEUE_CYC; // RULE_07
		else if (is_write)
			w = ahbw_pkg::WR_WAIT_TYP_CYC; // RULE_07
		else if (turbo)
			w = ahbw_pkg::RD_WAIT_TURBO_CYC; // RULE_05
		else
			w = ahbw_pkg::RD_WAIT_NORMAL_CYC; // RULE_04
		return w;
	endfunction

	logic [ahbw_pkg::CNT_W-1:0] rd_wait;
	logic [ahbw_pkg::CNT_W-1:0] wr_wait;

	// turbo only shortens the wait when the strap says the driver uses it
	assign rd_wait = wait_cycles(1'b0, rd_addr, turbo_mode); // RULE_06
	assign wr_wait = wait_cycles(1'b1, wr_addr, turbo_mode);

	// ------------------------------------------------------------
	// ready line and wait counter
	// ------------------------------------------------------------
	logic [ahbw_pkg::CNT_W-1:0] wait_cnt;

	// a fresh start always reloads, even mid-wait of the last access;
	// a read wins over a write release landing in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wait_cnt         <= ahbw_pkg::CNT_RST;
			bus.access_ready <= 1'b1;
		end
		else if (rd_start)
		begin
			wait_cnt         <= rd_wait; // RULE_02
			bus.access_ready <= (rd_wait == ahbw_pkg::CNT_RST); // RULE_08
		end
		else if (wr_end)
		begin
			wait_cnt         <= wr_wait; // RULE_02
			bus.access_ready <= (wr_wait == ahbw_pkg::CNT_RST); // RULE_09
		end
		else if (wait_cnt != ahbw_pkg::CNT_RST)
		begin
			wait_cnt <= wait_cnt - 1'b1;
			if (wait_cnt == 5'h01)
				bus.access_ready <= 1'b1; // RULE_01
		end
	end

	// ------------------------------------------------------------
	// register side strobes
	// ------------------------------------------------------------
	// one-cycle pulses towards the register file, address alongside
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			reg_rd    <= 1'b0;
			reg_wr    <= 1'b0;
			reg_addr  <= ahbw_pkg::ADDR_RST;
			reg_qual  <= 1'b0;
			reg_be_n  <= ahbw_pkg::BE_N_RST;
			reg_wdata <= ahbw_pkg::DATA_RST;
		end
		else
		begin
			reg_rd <= rd_start;
			reg_wr <= wr_end & ~rd_start;
			if (rd_start)
			begin
				reg_addr <= rd_addr;
				reg_qual <= rd_qual;
				reg_be_n <= rd_be_n;
			end
			else if (wr_end)
			begin
				reg_addr  <= wr_addr;
				reg_qual  <= wr_qual;
				reg_be_n  <= wr_be_n;
				reg_wdata <= bus.data; // RULE_11
			end
		end
	end

	// ------------------------------------------------------------
	// read data return
	// ------------------------------------------------------------
	// the register file answers in the reg_rd cycle, taken at its end; shortest
	// non-zero wait is far longer, so data settles before ready rises
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bus.dev_data <= ahbw_pkg::DATA_RST;
		end
		else if (reg_rd)
		begin
			bus.dev_data <= reg_rdata; // RULE_10
		end
	end

	// drive the data wire from a cycle after the read strobe falls to a cycle after it rises
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bus.dev_data_oe <= 1'b0;
		else
			bus.dev_data_oe <= ~bus.read_strobe_n;
	end

endmodule

// file: src/ahbw_pkg.sv
// shared constants and types for the wait-handshake host port
package ahbw_pkg;

	// ------------------------------------------------------------
	// bus widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// ------------------------------------------------------------
	// register locations that change the wait length
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] BANK_SEL_ADDR  = 15'h0007;
	localparam logic [ADDR_W-1:0] QUEUE_DATA_ADDR = 15'h0004;

	// ------------------------------------------------------------
	// times in ns and derived cycle counts at 200 MHz
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 5;
	localparam int RD_WAIT_NORMAL_NS  = 80;
	localparam int RD_WAIT_TURBO_NS   = 40;
	localparam int WR_WAIT_QUEUE_NS   = 36;
	localparam int WR_WAIT_TYP_NS     = 50;
	localparam int BANK_SEL_WAIT_NS   = 0;

	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] RD_WAIT_NORMAL_CYC =
		CNT_W'((RD_WAIT_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] RD_WAIT_TURBO_CYC =
		CNT_W'((RD_WAIT_TURBO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WR_WAIT_QUEUE_CYC =
		CNT_W'((WR_WAIT_QUEUE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WR_WAIT_TYP_CYC =
		CNT_W'((WR_WAIT_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] BANK_SEL_WAIT_CYC =
		CNT_W'(BANK_SEL_WAIT_NS / CLK_PERIOD_NS);

	// host holds a strobe at least this many cycles before looking at ready
	localparam int HCNT_W = 3;
	localparam logic [HCNT_W-1:0] STROBE_MIN_CYC = 3'h4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
	localparam logic [BE_W-1:0]   BE_N_RST = 4'hf;
	localparam logic [CNT_W-1:0]  CNT_RST  = 5'h00;

	// ------------------------------------------------------------
	// host sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		H_IDLE   = 2'b00,
		H_ADDR   = 2'b01,
		H_STROBE = 2'b10,
		H_HOLD   = 2'b11
	} ahbw_hstate_e;

endpackage

// file: src/ahbw_if.sv
// pin bundle between the host and the device end
`timescale 1ns/100ps
interface ahbw_if (
	// common clock
	input wire logic clk
);
	logic [ahbw_pkg::ADDR_W-1:0] host_addr_lines;
	logic                        addr_qualifier;
	logic [ahbw_pkg::BE_W-1:0]   byte_lane_enable_n;
	logic                        addr_latch_strobe_n;
	logic                        read_strobe_n;
	logic                        write_strobe_n;
	logic                        access_ready;
	logic [ahbw_pkg::DATA_W-1:0] host_data;
	logic                        host_data_oe;
	logic [ahbw_pkg::DATA_W-1:0] dev_data;
	logic                        dev_data_oe;
	logic [ahbw_pkg::DATA_W-1:0] data;

	// shared data wire level; the host wins if both drive
	assign data = host_data_oe ? host_data : (dev_data_oe ? dev_data : ahbw_pkg::DATA_RST);

	modport host (
		input  clk,
		output host_addr_lines,
		output addr_qualifier,
		output byte_lane_enable_n,
		output addr_latch_strobe_n,
		output read_strobe_n,
		output write_strobe_n,
		output host_data,
		output host_data_oe,
		input  access_ready,
		input  data
	);

	modport dev (
		input  clk,
		input  host_addr_lines,
		input  addr_qualifier,
		input  byte_lane_enable_n,
		input  addr_latch_strobe_n,
		input  read_strobe_n,
		input  write_strobe_n,
		output dev_data,
		output dev_data_oe,
		output access_ready,
		input  data
	);
endinterface

// file: src/ahbw_host_end.sv
// host end: sequences one read or write per command over the wait-handshake port
`timescale 1ns/100ps
module ahbw_host_end (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// device pins
	ahbw_if.host                             bus,
	// mode select
	input  wire logic                        strobe_mode,
	// command side
	input  wire logic                        cmd_valid,
	input  wire logic                        cmd_write,
	input  wire logic [ahbw_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic                        cmd_qual,
	input  wire logic [ahbw_pkg::BE_W-1:0]   cmd_be_n,
	input  wire logic [ahbw_pkg::DATA_W-1:0] cmd_wdata,
	output logic                             cmd_ready,
	// response side
	output logic                             rsp_valid,
	output logic [ahbw_pkg::DATA_W-1:0]      rsp_rdata
);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	ahbw_pkg::ahbw_hstate_e       state;
	logic [ahbw_pkg::HCNT_W-1:0]  hold_cnt;
	logic                         is_write;

	// a new command may start while ready is still low from the last one
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state                   <= ahbw_pkg::H_IDLE;
			hold_cnt                <= 3'h0;
			is_write                <= 1'b0;
			cmd_ready               <= 1'b1;
			rsp_valid               <= 1'b0;
			rsp_rdata               <= ahbw_pkg::DATA_RST;
			bus.host_addr_lines     <= ahbw_pkg::ADDR_RST;
			bus.addr_qualifier      <= 1'b0;
			bus.byte_lane_enable_n  <= ahbw_pkg::BE_N_RST;
			bus.addr_latch_strobe_n <= 1'b1;
			bus.read_strobe_n       <= 1'b1;
			bus.write_strobe_n      <= 1'b1;
			bus.host_data           <= ahbw_pkg::DATA_RST;
			bus.host_data_oe        <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			case (state)
				ahbw_pkg::H_IDLE:
				begin
					if (cmd_valid)
					begin
						cmd_ready              <= 1'b0;
						is_write               <= cmd_write;
						hold_cnt               <= 3'h0;
						bus.host_addr_lines    <= cmd_addr;
						bus.addr_qualifier     <= cmd_qual;
						bus.byte_lane_enable_n <= cmd_be_n;
						bus.host_data          <= cmd_wdata;
						bus.host_data_oe       <= cmd_write;
						if (strobe_mode)
						begin
							bus.addr_latch_strobe_n <= 1'b0;
							state                   <= ahbw_pkg::H_ADDR;
						end
						else
						begin
							bus.read_strobe_n  <= cmd_write; // RULE_02
							bus.write_strobe_n <= ~cmd_write;
							state              <= ahbw_pkg::H_STROBE;
						end
					end
				end
				ahbw_pkg::H_ADDR:
				begin
					// rising edge here is where the device latches
					bus.addr_latch_strobe_n <= 1'b1; // RULE_12
					bus.read_strobe_n       <= is_write;
					bus.write_strobe_n      <= ~is_write;
					state                   <= ahbw_pkg::H_STROBE;
				end
				ahbw_pkg::H_STROBE:
				begin
					if (hold_cnt != ahbw_pkg::STROBE_MIN_CYC)
						hold_cnt <= hold_cnt + 3'h1;
					else if (bus.access_ready)
					begin
						// release only once ready is back high
						bus.read_strobe_n  <= 1'b1; // RULE_01
						bus.write_strobe_n <= 1'b1; // RULE_01
						if (!is_write)
						begin
							rsp_valid <= 1'b1;
							rsp_rdata <= bus.data; // RULE_10
						end
						state <= ahbw_pkg::H_HOLD;
					end
				end
				ahbw_pkg::H_HOLD:
				begin
					// address and data stay one cycle past the release
					bus.host_data_oe <= 1'b0; // RULE_11
					cmd_ready        <= 1'b1; // RULE_13
					state            <= ahbw_pkg::H_IDLE;
				end
				default:
				begin
					state <= ahbw_pkg::H_IDLE;
				end
			endcase
		end
	end

endmodule

// file: verif/ahbw_chk.sv
// pin-level checker for the wait-handshake host port
`timescale 1ns/100ps
module ahbw_chk (
	// clock, reset and modes
	input wire logic				clk,
	input wire logic				rst_n,
	input wire logic				turbo_mode,
	input wire logic				addr_strobe_mode,
	// host pins
	input wire logic [ahbw_pkg::ADDR_W-1:0]	host_addr_lines,
	input wire logic				addr_latch_strobe_n,
	input wire logic				read_strobe_n,
	input wire logic				write_strobe_n,
	input wire logic				access_ready,
	input wire logic [ahbw_pkg::DATA_W-1:0]	dev_data,
	input wire logic				dev_data_oe,
	input wire logic [ahbw_pkg::DATA_W-1:0]	data,
	// device register side
	input wire logic				reg_rd,
	input wire logic				reg_wr,
	input wire logic [ahbw_pkg::ADDR_W-1:0]	reg_addr,
	input wire logic [ahbw_pkg::DATA_W-1:0]	reg_wdata
);
	// ----------
	// helper state
	// ----------
	logic				rd_q, wr_q, lat_q, k_rd, k_tb, k_q, k_b;
	logic				rd_go, wr_go, bank;
	logic [4:0]			low_cnt;
	logic [ahbw_pkg::ADDR_W-1:0]	lat_addr;

	// start edges as the device sees them; read wins a tie
	assign rd_go = rd_q && !read_strobe_n;
	assign wr_go = !wr_q && write_strobe_n && !rd_go;
	assign bank = host_addr_lines == ahbw_pkg::BANK_SEL_ADDR;

	// low-time count restarts at every start, like the reload in the device
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_q <= 1'b1;
			wr_q <= 1'b1;
			lat_q <= 1'b1;
			low_cnt <= '0;
			lat_addr <= '0;
			k_rd <= 1'b0;
			k_tb <= 1'b0;
			k_q <= 1'b0;
			k_b <= 1'b0;
		end
		else
		begin
			rd_q <= read_strobe_n;
			wr_q <= write_strobe_n;
			lat_q <= addr_latch_strobe_n;
			if (!lat_q && addr_latch_strobe_n)
				lat_addr <= host_addr_lines;
			if (rd_go || wr_go)
			begin
				low_cnt <= '0;
				k_rd <= rd_go;
				k_tb <= turbo_mode;
				k_q <= host_addr_lines == ahbw_pkg::QUEUE_DATA_ADDR;
				k_b <= bank;
			end
			else if (!access_ready)
				low_cnt <= low_cnt + 5'h01;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ----------
	// assertions
	// ----------
	chk_host_strobe_hold: assert property ((!read_strobe_n || !write_strobe_n) && !access_ready
		|=> $stable({read_strobe_n, write_strobe_n})) else $error("strobe released during wait");
	chk_new_access_ok: assert property ((rd_go || wr_go) && !access_ready |=> reg_rd || reg_wr)
		else $error("access during wait lost");
	chk_bank_no_wait: assert property ((rd_go || wr_go) && bank |=> access_ready [*2])
		else $error("bank select waited");
	chk_rd_normal_len: assert property ($rose(access_ready) && k_rd && !k_tb
		|-> low_cnt == (k_b ? ahbw_pkg::BANK_SEL_WAIT_CYC : ahbw_pkg::RD_WAIT_NORMAL_CYC))
		else $error("normal read wait length");
	chk_rd_turbo_len: assert property ($rose(access_ready) && k_rd && k_tb
		|-> low_cnt == (k_b ? ahbw_pkg::BANK_SEL_WAIT_CYC : ahbw_pkg::RD_WAIT_TURBO_CYC))
		else $error("turbo read wait length");
	chk_wr_wait_len: assert property ($rose(access_ready) && !k_rd
		|-> low_cnt == (k_b ? ahbw_pkg::BANK_SEL_WAIT_CYC :
		(k_q ? ahbw_pkg::WR_WAIT_QUEUE_CYC : ahbw_pkg::WR_WAIT_TYP_CYC)))
		else $error("write wait length");
	chk_rd_ready_low: assert property (rd_go && !bank |=> !access_ready)
		else $error("ready not low after read start");
	chk_wr_ready_low: assert property (wr_go && !bank |=> !access_ready)
		else $error("ready not low after write end");
	chk_rd_data_valid: assert property ($rose(access_ready) && !read_strobe_n
		|-> dev_data_oe && data == dev_data) else $error("read data not driven at ready");
	chk_wr_data_take: assert property (wr_go |=> reg_wr && reg_wdata == $past(data))
		else $error("write data not captured");
	chk_latch_addr_use: assert property (addr_strobe_mode && rd_go |=> reg_rd && reg_addr == lat_addr)
		else $error("latched address not used");

	cov_rd_normal: cover property ($rose(access_ready) && k_rd && !k_tb);
	cov_rd_turbo: cover property ($rose(access_ready) && k_rd && k_tb);
	cov_wr_wait: cover property ($rose(access_ready) && !k_rd);
	cov_b2b: cover property ((rd_go || wr_go) && !access_ready);
endmodule

// file: verif/testbench.sv
// self-checking bench joining the host end to the device end
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
	logic				clk = 1'b0;
	logic				rst_n = 1'b0;
	logic				turbo_mode, strobe_mode;
	logic				cmd_valid, cmd_write, cmd_qual, cmd_ready, rsp_valid;
	logic [ahbw_pkg::ADDR_W-1:0]	cmd_addr, reg_addr, cap_a;
	logic [ahbw_pkg::BE_W-1:0]	cmd_be_n, reg_be_n, cap_be;
	logic [ahbw_pkg::DATA_W-1:0]	cmd_wdata, rsp_rdata, reg_wdata, reg_rdata, cap_wd;
	logic				reg_rd, reg_wr, reg_qual, cap_v, cap_q;
	int				lo, num_errors = 0, n_compared = 0;
	localparam logic [ahbw_pkg::ADDR_W-1:0] QA = ahbw_pkg::QUEUE_DATA_ADDR;

	always #2.5 clk = ~clk;

	ahbw_if bus_if (.clk(clk));
	ahbw_host_end ahbw_host_end_i (.clk(clk), .rst_n(rst_n), .bus(bus_if.host), .strobe_mode(strobe_mode),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_qual(cmd_qual),
		.cmd_be_n(cmd_be_n), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata));
	ahbw_dev_end ahbw_dev_end_i (.clk(clk), .rst_n(rst_n), .bus(bus_if.dev), .turbo_mode(turbo_mode),
		.addr_strobe_mode(strobe_mode), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_qual(reg_qual), .reg_be_n(reg_be_n), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	ahbw_chk ahbw_chk_i (.clk(clk), .rst_n(rst_n), .turbo_mode(turbo_mode), .addr_strobe_mode(strobe_mode),
		.host_addr_lines(bus_if.host_addr_lines), .addr_latch_strobe_n(bus_if.addr_latch_strobe_n),
		.read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
		.access_ready(bus_if.access_ready), .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe),
		.data(bus_if.data), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// register-side capture and ready-low cycle count
	always @(posedge clk)
	begin
		if (reg_wr === 1'b1)
		begin
			cap_v <= 1'b1;
			cap_wd <= reg_wdata;
			cap_a <= reg_addr;
			cap_be <= reg_be_n;
			cap_q <= reg_qual;
		end
		// restart at every start the device takes, so a wait left over
		// from a back-to-back access does not add to the next count
		if (reg_rd === 1'b1 || reg_wr === 1'b1)
			lo <= (bus_if.access_ready === 1'b0) ? 1 : 0;
		else if (bus_if.access_ready === 1'b0)
			lo <= lo + 1;
	end

	// verdict and end of run
	task automatic summarize();
		$display("errors %0d compares %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// a used-up wait bound is a hang: count it and close
	task automatic hang_check(input int n);
		if (n >= 99)
		begin
			num_errors++;
			summarize();
		end
	endtask

	// one command; ew below zero skips the wait-length check (back-to-back use)
	task automatic access(input logic w, input logic [14:0] a, input logic [31:0] d, input int ew);
		int n;
		@(negedge clk);
		for (n = 0; n < 99 && cmd_ready !== 1'b1; n++)
			@(negedge clk);
		hang_check(n);
		{cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {1'b1, w, a, d};
		{cmd_be_n, cmd_qual, reg_rdata, lo, cap_v} = {d[3:0], d[4], ~d, 32'h0, 1'b0};
		@(negedge clk);
		cmd_valid = 1'b0;
		for (n = 0; n < 99 && (w ? cap_v !== 1'b1 : rsp_valid !== 1'b1); n++)
			@(negedge clk);
		hang_check(n);
		if (!w)
			`CHK(rsp_rdata, ~d, "read data")
		else
		begin
			`CHK(cap_wd, d, "write data")
			`CHK({cap_a, cap_be, cap_q}, {a, d[3:0], d[4]}, "write address")
		end
		if (ew >= 0)
		begin
			for (n = 0; n < 99 && bus_if.access_ready !== 1'b1; n++)
				@(negedge clk);
			hang_check(n);
			`CHK(lo, ew, "ready low cycles")
		end
	endtask

	// queue and other reads in every strobe and speed mode
	task automatic t_reads();
		for (int m = 0; m < 4; m++)
		begin
			{turbo_mode, strobe_mode} = m[1:0];
			access(1'b0, QA, 32'h1234_5670 + m, m[1] ? 8 : 16);
			access(1'b0, 15'h0012, 32'ha5a5_0f00 + m, m[1] ? 8 : 16);
		end
	endtask

	// queue and other writes in both strobe modes
	task automatic t_writes();
		for (int m = 0; m < 2; m++)
		begin
			strobe_mode = m[0];
			access(1'b1, QA, 32'hcafe_0011 + m, 8);
			access(1'b1, 15'h0021, 32'h0bad_f00d + m, 10);
		end
	endtask

	// bank select never waits, also straight after a long wait
	task automatic t_bank();
		access(1'b0, ahbw_pkg::BANK_SEL_ADDR, 32'h0000_5a5a, 0);
		access(1'b1, ahbw_pkg::BANK_SEL_ADDR, 32'h0000_a5a5, 0);
	endtask

	// an access that follows a write starts while ready is still low
	task automatic t_b2b();
		access(1'b1, QA, 32'h7777_0003, -1);
		access(1'b0, QA, 32'h8888_0004, -1);
		access(1'b1, QA, 32'h9999_0005, -1);
		access(1'b1, 15'h0044, 32'h6666_0006, -1);
		access(1'b0, 15'h0045, 32'h5555_0007, 8);
	endtask

	initial
	begin
		{turbo_mode, strobe_mode, cmd_valid, cmd_write, cmd_qual} = '0;
		{cmd_addr, cmd_be_n, cmd_wdata, reg_rdata, lo, cap_v} = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_reads();
		t_writes();
		t_bank();
		t_b2b();
		summarize();
	end
endmodule
